/* rtl/cvtf_regs.vh */
// register map, field positions, reset values and timing counts of the cell threshold fault block
`ifndef CVTF_REGS_VH
`define CVTF_REGS_VH

`define CVTF_ADDR_LOW_RECOVERY_LO 8'h06
`define CVTF_ADDR_LOW_RECOVERY_HI 8'h07
`define CVTF_ADDR_HIGH_LOCKOUT_LO 8'h08
`define CVTF_ADDR_HIGH_LOCKOUT_HI 8'h09
`define CVTF_ADDR_LOW_LOCKOUT_LO 8'h0A
`define CVTF_ADDR_LOW_LOCKOUT_HI 8'h0B
`define CVTF_ADDR_FULL_CHARGE_LO 8'h0C
`define CVTF_ADDR_FULL_CHARGE_HI 8'h0D
`define CVTF_ADDR_FAULT_STATUS 8'h80
`define CVTF_ADDR_CELL_STATUS 8'h81

`define CVTF_RST_LOW_RECOVERY_LO 8'hFF
`define CVTF_RST_LOW_RECOVERY_HI 4'h9
`define CVTF_RST_HIGH_LOCKOUT_LO 8'h7F
`define CVTF_RST_HIGH_LOCKOUT_HI 4'hE
`define CVTF_RST_LOW_LOCKOUT_LO 8'h00
`define CVTF_RST_LOW_LOCKOUT_HI 4'h6
`define CVTF_RST_FULL_CHARGE_LO 8'hFF
`define CVTF_RST_FULL_CHARGE_HI 4'hD

`define CVTF_BIT_HIGH_LOCKOUT_FLAG 1
`define CVTF_BIT_LOW_FAULT_FLAG 2
`define CVTF_BIT_LOW_LOCKOUT_FLAG 3
`define CVTF_BIT_FULL_CHARGE_FLAG 7

`define CVTF_HIGH_LOCKOUT_OFF 12'hFFF
`define CVTF_LOW_LOCKOUT_OFF 12'h000
`define CVTF_LOCKOUT_COUNT 3'h5

`define CVTF_CLK_PERIOD_NS 5
`define CVTF_US_NS 1000
`define CVTF_CYCLES_PER_US (`CVTF_US_NS / `CVTF_CLK_PERIOD_NS)
`define CVTF_US_PER_MS 1000
`define CVTF_MS_PER_S 1000
`define CVTF_S_PER_MIN 60

`define CVTF_UNIT_US 2'h0
`define CVTF_UNIT_MS 2'h1
`define CVTF_UNIT_S 2'h2
`define CVTF_UNIT_MIN 2'h3

`endif

/* rtl/cvtf_delay_timer.v */
// delay timer: counts a 10-bit number of us/ms/s/min units while its condition holds
`timescale 1ns/100ps
`include "cvtf_regs.vh"
module cvtf_delay_timer #(
	parameter CYCLES_PER_US = `CVTF_CYCLES_PER_US,
	parameter US_PER_MS = `CVTF_US_PER_MS,
	parameter MS_PER_S = `CVTF_MS_PER_S,
	parameter S_PER_MIN = `CVTF_S_PER_MIN
) (
	input wire core_clk,
	input wire srst,
	input wire run,
	input wire [9:0] delayCount,
	input wire [1:0] delayUnit,
	output reg expired
);
	reg [15:0] cycCnt;
	reg [9:0] usCnt;
	reg [9:0] msCnt;
	reg [5:0] secCnt;
	reg [9:0] unitCnt;
	wire usTick;
	wire msTick;
	wire sTick;
	wire minTick;
	reg unitTick;

	assign usTick = (cycCnt == CYCLES_PER_US - 1);
	assign msTick = usTick && (usCnt == US_PER_MS - 1);
	assign sTick = msTick && (msCnt == MS_PER_S - 1);
	assign minTick = sTick && (secCnt == S_PER_MIN - 1);

	always @* begin
		case (delayUnit)
			`CVTF_UNIT_US: unitTick = usTick;
			`CVTF_UNIT_MS: unitTick = msTick;
			`CVTF_UNIT_S: unitTick = sTick;
			default: unitTick = minTick;
		endcase
	end

	// prescalers restart with the condition so each delay starts from a whole unit
	always @(posedge core_clk) begin
		if (srst || !run) begin
			cycCnt <= 16'h0000;
			usCnt <= 10'h000;
			msCnt <= 10'h000;
			secCnt <= 6'h00;
			unitCnt <= 10'h000;
			expired <= 1'b0;
		end else begin
			cycCnt <= usTick ? 16'h0000 : cycCnt + 16'h0001;
			if (usTick) begin
				usCnt <= msTick ? 10'h000 : usCnt + 10'h001;
			end
			if (msTick) begin
				msCnt <= sTick ? 10'h000 : msCnt + 10'h001;
			end
			if (sTick) begin
				secCnt <= minTick ? 6'h00 : secCnt + 6'h01;
			end
			if (unitCnt >= delayCount) begin
				expired <= 1'b1;
			end else if (unitTick) begin
				unitCnt <= unitCnt + 10'h001;
			end
		end
	end
endmodule

/* rtl/cvtf_threshold_faults.v */
// cell voltage threshold comparison, lockout and end-of-charge fault logic with its byte registers
//
// Summary of operation
// - low-recovery threshold at 0x06/0x07, reserved bits zero
// - low fault clears after recovery held for delay
// - low-recovery threshold ends undervoltage lockout
// - codes compared directly, same scaling everywhere
// - high-lockout threshold at 0x08/0x09, reserved zero
// - five high scans: lockout, charge and balance FETs off, shutdown
// - charge and precharge forced off during high lockout
// - high-lockout threshold 0xFFF disables detection
// - high lockout clears below high-recovery threshold
// - low-lockout threshold at 0x0A/0x0B, reserved zero
// - five low scans: lockout, discharge, balance off
// - low lockout forces powerdown when enabled
// - low-lockout threshold zero disables detection
// - full-charge level at 0x0C/0x0D, reserved zero
// - cell above level sets flag, output low
// - full charge steers balancing per configuration
// - low too long flags; discharge off when enabled, no host control
// - low delay is count times selected unit
`timescale 1ns/100ps
`include "cvtf_regs.vh"
module cvtf_threshold_faults #(
	parameter CELLS = 8,
	parameter CYCLES_PER_US = `CVTF_CYCLES_PER_US
) (
	input wire core_clk,
	input wire srst,
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [7:0] regWrData,
	input wire regRead,
	output reg [7:0] regRdData,
	input wire cellValid,
	input wire [11:0] cellCode,
	input wire cellLast,
	input wire [11:0] cellLowThreshold,
	input wire [11:0] highRecoveryThreshold,
	input wire [9:0] lowDelayCount,
	input wire [1:0] lowDelayUnit,
	input wire dischargeOffOnLowEnable,
	input wire hostFetControl,
	input wire lockoutPowerdownEnable,
	input wire balanceStopAtFull,
	input wire chargeRequest,
	input wire prechargeRequest,
	input wire dischargeRequest,
	input wire [CELLS-1:0] balanceRequest,
	output reg chargeFetDrive,
	output reg prechargeFetDrive,
	output reg dischargeFetDrive,
	output reg [CELLS-1:0] balanceFetDrive,
	output reg packShutdownOutput,
	output reg fullChargeN,
	output reg powerdownRequest,
	output reg lowFaultFlag,
	output reg highLockoutFlag,
	output reg lowLockoutFlag,
	output reg fullChargeFlag
);
	reg [7:0] lowRecoveryLo;
	reg [3:0] lowRecoveryHi;
	reg [7:0] highLockoutLo;
	reg [3:0] highLockoutHi;
	reg [7:0] lowLockoutLo;
	reg [3:0] lowLockoutHi;
	reg [7:0] fullChargeLo;
	reg [3:0] fullChargeHi;
	wire [11:0] lowRecoveryThreshold;
	wire [11:0] highLockoutThreshold;
	wire [11:0] lowLockoutThreshold;
	wire [11:0] fullChargeLevel;

	// per-scan accumulators, folded in as each cell arrives
	reg accAboveLockout;
	reg accBelowLockout;
	reg accBelowLow;
	reg accNotAboveRecovery;
	reg accNotBelowHighRecovery;
	reg accAboveFull;
	wire next_accAboveLockout;
	wire next_accBelowLockout;
	wire next_accBelowLow;
	wire next_accNotAboveRecovery;
	wire next_accNotBelowHighRecovery;
	wire next_accAboveFull;

	// results of the last finished scan, held until the next one ends
	reg scanBelowLow;
	reg scanAllAboveRecovery;
	wire scanEnd;

	reg [2:0] highLockoutCnt;
	reg [2:0] lowLockoutCnt;
	wire highLockoutOn;
	wire lowLockoutOn;

	reg lowFaultPrev;
	wire lowTimerRun;
	wire lowTimerExpired;
	reg [7:0] next_regRdData;

	assign lowRecoveryThreshold = {lowRecoveryHi, lowRecoveryLo};
	assign highLockoutThreshold = {highLockoutHi, highLockoutLo};
	assign lowLockoutThreshold = {lowLockoutHi, lowLockoutLo};
	assign fullChargeLevel = {fullChargeHi, fullChargeLo};

	assign highLockoutOn = (highLockoutThreshold != `CVTF_HIGH_LOCKOUT_OFF);
	assign lowLockoutOn = (lowLockoutThreshold != `CVTF_LOW_LOCKOUT_OFF);

	// all thresholds share the code-to-volt scaling, so raw codes compare directly
	assign next_accAboveLockout = accAboveLockout || (cellCode > highLockoutThreshold);
	assign next_accBelowLockout = accBelowLockout || (cellCode < lowLockoutThreshold);
	assign next_accBelowLow = accBelowLow || (cellCode < cellLowThreshold);
	assign next_accNotAboveRecovery = accNotAboveRecovery || (cellCode <= lowRecoveryThreshold);
	assign next_accNotBelowHighRecovery = accNotBelowHighRecovery || (cellCode >= highRecoveryThreshold);
	assign next_accAboveFull = accAboveFull || (cellCode > fullChargeLevel);
	assign scanEnd = cellValid && cellLast;

	// byte registers; reserved upper nibbles are not stored and read back as zero
	always @(posedge core_clk) begin
		if (srst) begin
			lowRecoveryLo <= `CVTF_RST_LOW_RECOVERY_LO;
			lowRecoveryHi <= `CVTF_RST_LOW_RECOVERY_HI;
			highLockoutLo <= `CVTF_RST_HIGH_LOCKOUT_LO;
			highLockoutHi <= `CVTF_RST_HIGH_LOCKOUT_HI;
			lowLockoutLo <= `CVTF_RST_LOW_LOCKOUT_LO;
			lowLockoutHi <= `CVTF_RST_LOW_LOCKOUT_HI;
			fullChargeLo <= `CVTF_RST_FULL_CHARGE_LO;
			fullChargeHi <= `CVTF_RST_FULL_CHARGE_HI;
		end else if (regWrite) begin
			case (regAddr)
				`CVTF_ADDR_LOW_RECOVERY_LO: lowRecoveryLo <= regWrData;
				`CVTF_ADDR_LOW_RECOVERY_HI: lowRecoveryHi <= regWrData[3:0];
				`CVTF_ADDR_HIGH_LOCKOUT_LO: highLockoutLo <= regWrData;
				`CVTF_ADDR_HIGH_LOCKOUT_HI: highLockoutHi <= regWrData[3:0];
				`CVTF_ADDR_LOW_LOCKOUT_LO: lowLockoutLo <= regWrData;
				`CVTF_ADDR_LOW_LOCKOUT_HI: lowLockoutHi <= regWrData[3:0];
				`CVTF_ADDR_FULL_CHARGE_LO: fullChargeLo <= regWrData;
				`CVTF_ADDR_FULL_CHARGE_HI: fullChargeHi <= regWrData[3:0];
				default: begin
				end
			endcase
		end
	end

	always @* begin
		case (regAddr)
			`CVTF_ADDR_LOW_RECOVERY_LO: next_regRdData = lowRecoveryLo;
			`CVTF_ADDR_LOW_RECOVERY_HI: next_regRdData = {4'h0, lowRecoveryHi};
			`CVTF_ADDR_HIGH_LOCKOUT_LO: next_regRdData = highLockoutLo;
			`CVTF_ADDR_HIGH_LOCKOUT_HI: next_regRdData = {4'h0, highLockoutHi};
			`CVTF_ADDR_LOW_LOCKOUT_LO: next_regRdData = lowLockoutLo;
			`CVTF_ADDR_LOW_LOCKOUT_HI: next_regRdData = {4'h0, lowLockoutHi};
			`CVTF_ADDR_FULL_CHARGE_LO: next_regRdData = fullChargeLo;
			`CVTF_ADDR_FULL_CHARGE_HI: next_regRdData = {4'h0, fullChargeHi};
			`CVTF_ADDR_FAULT_STATUS: begin
				next_regRdData = 8'h00;
				next_regRdData[`CVTF_BIT_HIGH_LOCKOUT_FLAG] = highLockoutFlag;
				next_regRdData[`CVTF_BIT_LOW_FAULT_FLAG] = lowFaultFlag;
				next_regRdData[`CVTF_BIT_LOW_LOCKOUT_FLAG] = lowLockoutFlag;
			end
			`CVTF_ADDR_CELL_STATUS: begin
				next_regRdData = 8'h00;
				next_regRdData[`CVTF_BIT_FULL_CHARGE_FLAG] = fullChargeFlag;
			end
			default: next_regRdData = 8'h00;
		endcase
	end

	always @(posedge core_clk) begin
		if (srst) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			regRdData <= next_regRdData;
		end
	end

	// a scan is the run of measurements ending with cellLast; the accumulators restart after it
	always @(posedge core_clk) begin
		if (srst || scanEnd) begin
			accAboveLockout <= 1'b0;
			accBelowLockout <= 1'b0;
			accBelowLow <= 1'b0;
			accNotAboveRecovery <= 1'b0;
			accNotBelowHighRecovery <= 1'b0;
			accAboveFull <= 1'b0;
		end else if (cellValid) begin
			accAboveLockout <= next_accAboveLockout;
			accBelowLockout <= next_accBelowLockout;
			accBelowLow <= next_accBelowLow;
			accNotAboveRecovery <= next_accNotAboveRecovery;
			accNotBelowHighRecovery <= next_accNotBelowHighRecovery;
			accAboveFull <= next_accAboveFull;
		end
	end

	// lockout counters: consecutive failing scans; any passing scan starts over
	always @(posedge core_clk) begin
		if (srst) begin
			highLockoutCnt <= 3'h0;
			lowLockoutCnt <= 3'h0;
			highLockoutFlag <= 1'b0;
			lowLockoutFlag <= 1'b0;
			fullChargeFlag <= 1'b0;
			scanBelowLow <= 1'b0;
			scanAllAboveRecovery <= 1'b0;
		end else if (scanEnd) begin
			scanBelowLow <= next_accBelowLow;
			scanAllAboveRecovery <= !next_accNotAboveRecovery;
			fullChargeFlag <= next_accAboveFull;
			if (next_accAboveLockout && highLockoutOn) begin
				if (highLockoutCnt != `CVTF_LOCKOUT_COUNT) begin
					highLockoutCnt <= highLockoutCnt + 3'h1;
				end
			end else begin
				highLockoutCnt <= 3'h0;
			end
			if (next_accBelowLockout && lowLockoutOn) begin
				if (lowLockoutCnt != `CVTF_LOCKOUT_COUNT) begin
					lowLockoutCnt <= lowLockoutCnt + 3'h1;
				end
			end else begin
				lowLockoutCnt <= 3'h0;
			end
			// entry beats exit when both would happen on the same scan
			if (next_accAboveLockout && highLockoutOn && highLockoutCnt == `CVTF_LOCKOUT_COUNT - 3'h1) begin
				highLockoutFlag <= 1'b1;
			end else if (!next_accNotBelowHighRecovery) begin
				highLockoutFlag <= 1'b0;
			end
			if (next_accBelowLockout && lowLockoutOn && lowLockoutCnt == `CVTF_LOCKOUT_COUNT - 3'h1) begin
				lowLockoutFlag <= 1'b1;
			end else if (!next_accNotAboveRecovery) begin
				lowLockoutFlag <= 1'b0;
			end
		end
	end

	// one timer serves both directions: entry while clear, recovery while set;
	// the cycle after the flag flips holds it idle so the other direction starts from zero
	assign lowTimerRun = (lowFaultFlag == lowFaultPrev) && (lowFaultFlag ? scanAllAboveRecovery : scanBelowLow);

	cvtf_delay_timer #(
		.CYCLES_PER_US(CYCLES_PER_US)
	) lowDelay (
		.core_clk(core_clk),
		.srst(srst),
		.run(lowTimerRun),
		.delayCount(lowDelayCount),
		.delayUnit(lowDelayUnit),
		.expired(lowTimerExpired)
	);

	always @(posedge core_clk) begin
		if (srst) begin
			lowFaultFlag <= 1'b0;
			lowFaultPrev <= 1'b0;
		end else begin
			lowFaultPrev <= lowFaultFlag;
			if (lowTimerRun && lowTimerExpired) begin
				lowFaultFlag <= !lowFaultFlag;
			end
		end
	end

	// output drives; high lockout forces charge, precharge and balance off, low lockout discharge and balance; the low fault only when auto control applies
	always @(posedge core_clk) begin
		if (srst) begin
			chargeFetDrive <= 1'b0;
			prechargeFetDrive <= 1'b0;
			dischargeFetDrive <= 1'b0;
			balanceFetDrive <= {CELLS{1'b0}};
			packShutdownOutput <= 1'b0;
			fullChargeN <= 1'b1;
			powerdownRequest <= 1'b0;
		end else begin
			chargeFetDrive <= chargeRequest && !highLockoutFlag;
			prechargeFetDrive <= prechargeRequest && !highLockoutFlag;
			dischargeFetDrive <= dischargeRequest && !lowLockoutFlag
				&& !(lowFaultFlag && dischargeOffOnLowEnable && !hostFetControl);
			if (highLockoutFlag || lowLockoutFlag || (balanceStopAtFull && fullChargeFlag)) begin
				balanceFetDrive <= {CELLS{1'b0}};
			end else begin
				balanceFetDrive <= balanceRequest;
			end
			packShutdownOutput <= highLockoutFlag;
			fullChargeN <= !fullChargeFlag;
			powerdownRequest <= lowLockoutFlag && lockoutPowerdownEnable;
		end
	end
endmodule

/* testbench/cvtf_threshold_faults_asserts.sv */
// assertion checker for the cell threshold fault block
`timescale 1ns/100ps
module cvtf_faults_asserts #(
	parameter CELLS = 8
) (
	input wire core_clk,
	input wire srst,
	input wire [7:0] regAddr,
	input wire regRead,
	input wire [7:0] regRdData,
	input wire cellValid,
	input wire cellLast,
	input wire lockoutPowerdownEnable,
	input wire chargeFetDrive,
	input wire prechargeFetDrive,
	input wire dischargeFetDrive,
	input wire [CELLS-1:0] balanceFetDrive,
	input wire packShutdownOutput,
	input wire fullChargeN,
	input wire powerdownRequest,
	input wire highLockoutFlag,
	input wire lowLockoutFlag,
	input wire fullChargeFlag
);
	// saturating count of scans since reset; no lockout may start before five
	reg [2:0] scans;
	always @(posedge core_clk) begin
		if (srst)
			scans <= 3'h0;
		else if (cellValid && cellLast && scans != 3'h5)
			scans <= scans + 3'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence highOutputsOff;
		!chargeFetDrive && !prechargeFetDrive && packShutdownOutput;
	endsequence
	sequence lowLockHeld;
		lowLockoutFlag && lockoutPowerdownEnable ##1 lowLockoutFlag && lockoutPowerdownEnable;
	endsequence
	high_lock_outputs_a: assert property (highLockoutFlag |=> highOutputsOff)
		else $error("charge path or shutdown wrong in high lockout");
	shutdown_release_a: assert property (!highLockoutFlag |=> !packShutdownOutput)
		else $error("shutdown output held without lockout");
	balance_lock_a: assert property ((highLockoutFlag || lowLockoutFlag) |=> balanceFetDrive == {CELLS{1'b0}})
		else $error("balance drive on during lockout");
	discharge_lock_a: assert property (lowLockoutFlag |=> !dischargeFetDrive)
		else $error("discharge drive on during low lockout");
	powerdown_lock_a: assert property (lowLockHeld |-> powerdownRequest)
		else $error("no powerdown during low lockout");
	full_output_a: assert property (1'b1 |=> fullChargeN == !$past(fullChargeFlag))
		else $error("full charge output disagrees with flag");
	scan_update_a: assert property (!(cellValid && cellLast) |=> $stable({highLockoutFlag, lowLockoutFlag, fullChargeFlag}))
		else $error("flag moved outside scan end");
	entry_count_a: assert property ($rose(highLockoutFlag) || $rose(lowLockoutFlag) |-> scans == 3'h5)
		else $error("lockout before five scans");
	reserved_read_a: assert property (regRead && regAddr inside {8'h07, 8'h09, 8'h0B, 8'h0D} |=> regRdData[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	unmapped_read_a: assert property (regRead && regAddr > 8'h81 |=> regRdData == 8'h00)
		else $error("unmapped read nonzero");
	read_hold_a: assert property (!regRead |=> $stable(regRdData))
		else $error("read data changed without read");
endmodule

bind cvtf_threshold_faults cvtf_faults_asserts #(.CELLS(CELLS)) chk_i (.core_clk, .srst, .regAddr, .regRead,
	.regRdData, .cellValid, .cellLast, .lockoutPowerdownEnable, .chargeFetDrive, .prechargeFetDrive,
	.dischargeFetDrive, .balanceFetDrive, .packShutdownOutput, .fullChargeN, .powerdownRequest,
	.highLockoutFlag, .lowLockoutFlag, .fullChargeFlag);

/* testbench/cvtf_host_model.sv */
// register bus host standing in for the external microcontroller
`timescale 1ns/100ps
module cvtf_host_model (
	input wire core_clk,
	output reg [7:0] regAddr,
	output reg regWrite,
	output reg [7:0] regWrData,
	output reg regRead,
	input wire [7:0] regRdData
);
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regWrData = 8'h00;
		regRead = 1'b0;
	end
	task wr(input [7:0] a, input [7:0] d);
		@(negedge core_clk);
		regAddr = a;
		// reserved upper nibbles of the threshold high bytes go out as zero
		regWrData = (a[0] && a < 8'h0E) ? {4'h0, d[3:0]} : d;
		regWrite = 1'b1;
		@(negedge core_clk);
		regWrite = 1'b0;
		// stale data never looks valid once released
		regWrData = ~regWrData;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(negedge core_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge core_clk);
		regRead = 1'b0;
		regAddr = ~a;
		@(negedge core_clk);
		d = regRdData;
	endtask
endmodule

/* testbench/cvtf_threshold_faults_test.sv */
// self-checking bench for the cell threshold fault block
`timescale 1ns/100ps
module cvtf_threshold_faults_test;
	reg core_clk, srst, cellValid, cellLast;
	reg [11:0] cellCode, cellLowThreshold, highRecoveryThreshold;
	reg [9:0] lowDelayCount;
	reg [1:0] lowDelayUnit;
	reg dischargeOffOnLowEnable, hostFetControl, lockoutPowerdownEnable, balanceStopAtFull;
	reg chargeRequest, prechargeRequest, dischargeRequest;
	reg [7:0] balanceRequest, a, d;
	wire [7:0] regAddr, regWrData, regRdData, balanceFetDrive;
	wire regWrite, regRead, chargeFetDrive, prechargeFetDrive, dischargeFetDrive, packShutdownOutput;
	wire fullChargeN, powerdownRequest, lowFaultFlag, highLockoutFlag, lowLockoutFlag, fullChargeFlag;
	integer seed, k, i;
	integer fail_count = 0;
	integer checks_done = 0;
	cvtf_threshold_faults #(.CELLS(8), .CYCLES_PER_US(2)) dut (.core_clk, .srst, .regAddr, .regWrite,
		.regWrData, .regRead, .regRdData, .cellValid, .cellCode, .cellLast, .cellLowThreshold,
		.highRecoveryThreshold, .lowDelayCount, .lowDelayUnit, .dischargeOffOnLowEnable, .hostFetControl,
		.lockoutPowerdownEnable, .balanceStopAtFull, .chargeRequest, .prechargeRequest, .dischargeRequest,
		.balanceRequest, .chargeFetDrive, .prechargeFetDrive, .dischargeFetDrive, .balanceFetDrive,
		.packShutdownOutput, .fullChargeN, .powerdownRequest, .lowFaultFlag, .highLockoutFlag,
		.lowLockoutFlag, .fullChargeFlag);
	cvtf_host_model host (.core_clk, .regAddr, .regWrite, .regWrData, .regRead, .regRdData);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// reset value of each threshold byte; a case keeps free simulators happy
	function [7:0] rstExp(input [7:0] adr);
		case (adr)
			8'h06: rstExp = 8'hFF;
			8'h07: rstExp = 8'h09;
			8'h08: rstExp = 8'h7F;
			8'h09: rstExp = 8'h0E;
			8'h0A: rstExp = 8'h00;
			8'h0B: rstExp = 8'h06;
			8'h0C: rstExp = 8'hFF;
			default: rstExp = 8'h0D;
		endcase
	endfunction
	function [7:0] rdExp(input [7:0] adr, input [7:0] v);
		rdExp = (adr[0] && adr < 8'h0E) ? {4'h0, v[3:0]} : v;
	endfunction
	task chk(input [11:0] seen, input [11:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one scan of eight cells, the probed code on cell 3, the rest random mid-range
	// own random word, so a caller's loop counter is never overwritten
	task scan(input [11:0] c);
		integer r;
		for (i = 0; i < 8; i = i + 1) begin
			@(negedge core_clk);
			r = $random(seed);
			cellValid = 1'b1;
			cellCode = (i == 3) ? c : {4'h8, r[7:0]};
			cellLast = (i == 7);
		end
		@(negedge core_clk);
		cellValid = 1'b0;
		cellLast = 1'b0;
	endtask
	// flags land one edge after scan end, drives one edge later
	task settle;
		repeat (2) @(negedge core_clk);
	endtask
	task stop_test;
		$display("mismatches %0d, checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		seed = 68292;
		k = $random(seed);
		balanceRequest = k[7:0] | 8'h01;
		{cellValid, cellLast, cellCode} = 14'h0000;
		{cellLowThreshold, highRecoveryThreshold} = {12'h100, 12'hD00};
		{lowDelayCount, lowDelayUnit} = {10'h005, 2'h0};
		{dischargeOffOnLowEnable, hostFetControl, lockoutPowerdownEnable, balanceStopAtFull} = 4'hB;
		{chargeRequest, prechargeRequest, dischargeRequest} = 3'h7;
		srst = 1'b1;
		repeat (20) @(negedge core_clk);
		srst = 1'b0;
		for (a = 8'h06; a < 8'h0E; a = a + 8'h01) begin
			host.rd(a, d);
			chk(d, rstExp(a));
			k = $random(seed);
			host.wr(a, k[7:0]);
			host.rd(a, d);
			chk(d, rdExp(a, k[7:0]));
			host.wr(a, rstExp(a));
		end
		host.rd(8'hA5, d);
		chk(d, 8'h00);
		scan(12'hE00);
		settle;
		chk({fullChargeFlag, fullChargeN, balanceFetDrive}, 10'h200);
		balanceStopAtFull = 1'b0;
		settle;
		chk(balanceFetDrive, balanceRequest);
		balanceStopAtFull = 1'b1;
		repeat (4) scan(12'hF00);
		scan(12'h800);
		settle;
		chk(highLockoutFlag, 1'b0);
		for (k = 0; k < 5; k = k + 1) begin
			scan(12'hF00);
			settle;
			chk(highLockoutFlag, k == 4);
		end
		chk({chargeFetDrive, prechargeFetDrive, packShutdownOutput, balanceFetDrive}, 11'h100);
		host.rd(8'h80, d);
		chk(d, 8'h02);
		host.rd(8'h81, d);
		chk(d, 8'h80);
		scan(12'h800);
		settle;
		chk({highLockoutFlag, chargeFetDrive, prechargeFetDrive}, 3'h3);
		// recovery kept above the cell low threshold for hysteresis
		host.wr(8'h06, 8'h00);
		host.wr(8'h07, 8'h07);
		repeat (5) scan(12'h500);
		settle;
		chk({lowLockoutFlag, dischargeFetDrive, powerdownRequest}, 3'h5);
		scan(12'h800);
		settle;
		chk({lowLockoutFlag, dischargeFetDrive, powerdownRequest}, 3'h2);
		cellLowThreshold = 12'h400;
		scan(12'h300);
		settle;
		chk(lowFaultFlag, 1'b0);
		repeat (20) @(negedge core_clk);
		chk({lowFaultFlag, dischargeFetDrive}, 2'h2);
		scan(12'h800);
		settle;
		chk(lowFaultFlag, 1'b1);
		repeat (30) @(negedge core_clk);
		chk({lowFaultFlag, dischargeFetDrive}, 2'h1);
		hostFetControl = 1'b1;
		scan(12'h300);
		repeat (22) @(negedge core_clk);
		chk({lowFaultFlag, dischargeFetDrive}, 2'h3);
		// millisecond unit: one unit is 1000 prescaled microseconds
		{lowDelayCount, lowDelayUnit} = {10'h001, 2'h1};
		scan(12'h800);
		repeat (1990) @(negedge core_clk);
		chk(lowFaultFlag, 1'b1);
		repeat (20) @(negedge core_clk);
		chk(lowFaultFlag, 1'b0);
		stop_test;
	end
endmodule
